// File: cpsr_pkg.sv
/*
  Shared constants and carrier types for the processor status flag register.
  Assumes a single hclk domain and word-wide AHB-Lite register access.
*/
package cpsr_pkg;

  // register byte offsets, decoded on haddr[7:0]
  localparam logic [7:0] OFF_STATUS     = 8'h00;
  localparam logic [7:0] OFF_CORE_CTRL  = 8'h04;
  localparam logic [7:0] OFF_INTR_CTRL1 = 8'h08;
  localparam logic [7:0] OFF_EV_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_EV_CLEAR   = 8'h10;
  localparam logic [7:0] OFF_EV_ENABLE  = 8'h14;
  localparam logic [7:0] OFF_PRIORITY   = 8'h18;

  // status word field positions
  localparam int B_OA     = 15;
  localparam int B_OB     = 14;
  localparam int B_SA     = 13;
  localparam int B_SB     = 12;
  localparam int B_OAB    = 11;
  localparam int B_SAB    = 10;
  localparam int B_DA     = 9;
  localparam int B_DC     = 8;
  localparam int B_IPL_LO = 5;
  localparam int B_RA     = 4;
  localparam int B_N      = 3;
  localparam int B_OV     = 2;
  localparam int B_Z      = 1;
  localparam int B_C      = 0;

  // control register field positions
  localparam int B_IPL_MSB  = 3;
  localparam int B_NEST_DIS = 15;

  // event status / enable / clear bit positions
  localparam int EV_ACC_OVF = 0;
  localparam int EV_SAT     = 1;
  localparam int EV_ALU_OV  = 2;
  localparam int EV_W       = 3;

  localparam logic [2:0]  IPL_USER_OFF = 3'h7;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;

  // values after reset
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam logic        CORE_MSB_RST = 1'h0;
  localparam logic        NEST_DIS_RST = 1'h0;
  localparam logic [2:0]  EV_RST       = 3'h0;
  localparam logic [2:0]  EV_EN_RST    = 3'h0;

  typedef struct packed {
    logic        valid;
    logic        is_byte;
    logic        is_sub;
    logic [15:0] op_a;
    logic [15:0] op_b;
  } cpsr_alu_t;

  typedef struct packed {
    logic valid;
    logic ovf_a;
    logic ovf_b;
    logic sat_a;
    logic sat_b;
  } cpsr_acc_t;

  typedef struct packed {
    logic       load;
    logic [2:0] level;
  } cpsr_ipl_t;

endpackage

// File: cpsr_sticky.sv
/*
  Vector of sticky flags: set wins over clear in the same cycle.
  Assumes set and clr come from logic on the same clock.
*/
module cpsr_sticky #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q,
  output logic      [W-1:0] q_nxt
);

  logic [W-1:0] q_r;

  // an event landing on the clearing cycle must not be lost
  always_comb begin
    q_nxt = (q_r & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule // cpsr_sticky

// File: cpsr_flag_reg.sv
/*
  Processor status flag register with AHB-Lite access, ALU flag generation,
  accumulator flags, loop activity, priority level and event interrupt.
  Assumes ALU, accumulator, loop and priority sources run on hclk.
*/
// The AHB-Lite register port and the address map were chosen for this implementation.
// Operation
// RL1: priority field holds level 0..7 directly; 7 disables user interrupts.
// RL2: effective priority is the control msb above the three level bits.
// RL3: control msb set blocks user interrupts regardless of lower bits.
// RL4: nesting disable makes the priority field ignore software writes.
// RL5: status write sets saturation flags directly or clears both via combined bit.
// RL6: software should avoid bit operations on saturation flags.
// RL7: repeat flag reads one while a repeat loop runs; read-only.
// RL8: negative flag follows sign of the ALU result.
// RL9: signed overflow flag set when the sign bit changes wrongly.
// RL10: zero flag cleared by nonzero result, set by zero result.
// RL11: carry flag shows carry out of result msb.
// RL12: nibble carry from bit 3 for bytes, bit 7 for words.
// RL13: overflow flags per accumulator, combined OR, saturation flags sticky.
// RL14: loop flag reads one while a DO loop runs; read-only.
module cpsr_flag_reg (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire cpsr_pkg::cpsr_alu_t alu_upd,
  input  wire cpsr_pkg::cpsr_acc_t acc_upd,
  input  wire cpsr_pkg::cpsr_ipl_t ipl_upd,
  input  wire logic                do_loop_busy,
  input  wire logic                repeat_busy,
  output logic      [15:0]         cpu_status_reg,
  output logic      [3:0]          cpu_priority,
  output logic                     user_irq_blocked,
  output logic                     irq
);

  // bus state
  logic        dp_wr_r;
  logic        dp_wr_nxt;
  logic [7:0]  dp_addr_r;
  logic [7:0]  dp_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        hreadyout_r;
  logic        hresp_r;
  logic        addr_phase;

  // flag state
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic        core_msb_r;
  logic        core_msb_nxt;
  logic        nest_dis_r;
  logic        nest_dis_nxt;
  logic [2:0]  ev_en_r;
  logic [2:0]  ev_en_nxt;
  logic [3:0]  prio_r;
  logic        blocked_r;
  logic        irq_r;

  // events
  logic [2:0]  ev_set;
  logic [2:0]  ev_clr;
  logic [2:0]  ev_q;
  logic [2:0]  ev_q_nxt;

  // ALU datapath
  logic [15:0] b_eff;
  logic [16:0] sum_word;
  logic [8:0]  sum_byte;
  logic [4:0]  sum_nib;
  logic        alu_n;
  logic        alu_ov;
  logic        alu_z;
  logic        alu_c;
  logic        alu_dc;

  logic        wr_status;
  logic        wr_core;
  logic        wr_intr;
  logic        wr_ev_clr;
  logic        wr_ev_en;

  assign addr_phase = hsel && htrans[1] && hready;
  // only whole-word writes land; narrower ones are answered but dropped
  assign wr_status = dp_wr_r && (dp_addr_r == cpsr_pkg::OFF_STATUS);
  assign wr_core   = dp_wr_r && (dp_addr_r == cpsr_pkg::OFF_CORE_CTRL);
  assign wr_intr   = dp_wr_r && (dp_addr_r == cpsr_pkg::OFF_INTR_CTRL1);
  assign wr_ev_clr = dp_wr_r && (dp_addr_r == cpsr_pkg::OFF_EV_CLEAR);
  assign wr_ev_en  = dp_wr_r && (dp_addr_r == cpsr_pkg::OFF_EV_ENABLE);

  always_comb begin
    b_eff    = alu_upd.is_sub ? ~alu_upd.op_b : alu_upd.op_b;
    sum_word = {1'b0, alu_upd.op_a} + {1'b0, b_eff} + {16'h0000, alu_upd.is_sub};
    sum_byte = {1'b0, alu_upd.op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, alu_upd.is_sub};
    sum_nib  = {1'b0, alu_upd.op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_upd.is_sub};
    if (alu_upd.is_byte) begin
      alu_c  = sum_byte[8]; // see RL11
      alu_dc = sum_nib[4]; // see RL12
      alu_n  = sum_byte[7]; // see RL8
      alu_ov = (alu_upd.op_a[7] == b_eff[7]) && (sum_byte[7] != alu_upd.op_a[7]); // see RL9
      alu_z  = (sum_byte[7:0] == 8'h00); // see RL10
    end else begin
      alu_c  = sum_word[16]; // see RL11
      alu_dc = sum_byte[8]; // see RL12
      alu_n  = sum_word[15]; // see RL8
      alu_ov = (alu_upd.op_a[15] == b_eff[15]) && (sum_word[15] != alu_upd.op_a[15]); // see RL9
      alu_z  = (sum_word[15:0] == 16'h0000); // see RL10
    end
  end

  // software first, hardware last: a flag update in the write cycle wins
  always_comb begin
    status_nxt   = status_r;
    core_msb_nxt = core_msb_r;
    nest_dis_nxt = nest_dis_r;
    ev_en_nxt    = ev_en_r;
    if (wr_status) begin
      status_nxt[cpsr_pkg::B_OA] = hwdata[cpsr_pkg::B_OA];
      status_nxt[cpsr_pkg::B_OB] = hwdata[cpsr_pkg::B_OB];
      status_nxt[cpsr_pkg::B_DC] = hwdata[cpsr_pkg::B_DC];
      status_nxt[cpsr_pkg::B_N]  = hwdata[cpsr_pkg::B_N];
      status_nxt[cpsr_pkg::B_OV] = hwdata[cpsr_pkg::B_OV];
      status_nxt[cpsr_pkg::B_Z]  = hwdata[cpsr_pkg::B_Z];
      status_nxt[cpsr_pkg::B_C]  = hwdata[cpsr_pkg::B_C];
      if (!nest_dis_r) begin
        status_nxt[cpsr_pkg::B_IPL_LO +: 3] = hwdata[cpsr_pkg::B_IPL_LO +: 3]; // see RL4
      end
      if (!hwdata[cpsr_pkg::B_SAB]) begin
        status_nxt[cpsr_pkg::B_SA] = 1'b0; // see RL5
        status_nxt[cpsr_pkg::B_SB] = 1'b0;
      end else begin
        status_nxt[cpsr_pkg::B_SA] = hwdata[cpsr_pkg::B_SA]; // see RL5
        status_nxt[cpsr_pkg::B_SB] = hwdata[cpsr_pkg::B_SB];
      end
    end
    if (wr_core) begin
      core_msb_nxt = hwdata[cpsr_pkg::B_IPL_MSB];
    end
    if (wr_intr) begin
      nest_dis_nxt = hwdata[cpsr_pkg::B_NEST_DIS];
    end
    if (wr_ev_en) begin
      ev_en_nxt = hwdata[cpsr_pkg::EV_W-1:0];
    end
    if (alu_upd.valid) begin
      status_nxt[cpsr_pkg::B_N]  = alu_n;
      status_nxt[cpsr_pkg::B_OV] = alu_ov;
      status_nxt[cpsr_pkg::B_Z]  = alu_z;
      status_nxt[cpsr_pkg::B_C]  = alu_c;
      status_nxt[cpsr_pkg::B_DC] = alu_dc;
    end
    if (acc_upd.valid) begin
      status_nxt[cpsr_pkg::B_OA] = acc_upd.ovf_a; // see RL13
      status_nxt[cpsr_pkg::B_OB] = acc_upd.ovf_b;
      // saturation only ever sets here; software alone clears
      if (acc_upd.sat_a) begin
        status_nxt[cpsr_pkg::B_SA] = 1'b1; // see RL13
      end
      if (acc_upd.sat_b) begin
        status_nxt[cpsr_pkg::B_SB] = 1'b1;
      end
    end
    if (ipl_upd.load) begin
      status_nxt[cpsr_pkg::B_IPL_LO +: 3] = ipl_upd.level; // see RL1
    end
    status_nxt[cpsr_pkg::B_RA]  = repeat_busy; // see RL7
    status_nxt[cpsr_pkg::B_DA]  = do_loop_busy; // see RL14
    status_nxt[cpsr_pkg::B_OAB] = status_nxt[cpsr_pkg::B_OA] | status_nxt[cpsr_pkg::B_OB]; // see RL13
    status_nxt[cpsr_pkg::B_SAB] = status_nxt[cpsr_pkg::B_SA] | status_nxt[cpsr_pkg::B_SB];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r   <= cpsr_pkg::STATUS_RST;
      core_msb_r <= cpsr_pkg::CORE_MSB_RST;
      nest_dis_r <= cpsr_pkg::NEST_DIS_RST;
      ev_en_r    <= cpsr_pkg::EV_EN_RST;
      prio_r     <= 4'h0;
      blocked_r  <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      status_r   <= status_nxt;
      core_msb_r <= core_msb_nxt;
      nest_dis_r <= nest_dis_nxt;
      ev_en_r    <= ev_en_nxt;
      prio_r     <= {core_msb_nxt, status_nxt[cpsr_pkg::B_IPL_LO +: 3]}; // see RL2
      blocked_r  <= core_msb_nxt // see RL3
                    || (status_nxt[cpsr_pkg::B_IPL_LO +: 3] == cpsr_pkg::IPL_USER_OFF); // see RL1
      irq_r      <= |(ev_q_nxt & ev_en_nxt);
    end
  end

  always_comb begin
    ev_set                      = 3'h0;
    ev_set[cpsr_pkg::EV_ACC_OVF] = acc_upd.valid && (acc_upd.ovf_a || acc_upd.ovf_b);
    ev_set[cpsr_pkg::EV_SAT]     = acc_upd.valid && (acc_upd.sat_a || acc_upd.sat_b);
    ev_set[cpsr_pkg::EV_ALU_OV]  = alu_upd.valid && alu_ov;
    ev_clr                      = wr_ev_clr ? hwdata[cpsr_pkg::EV_W-1:0] : 3'h0;
  end

  cpsr_sticky #(
    .W       (cpsr_pkg::EV_W),
    .RST_VAL (cpsr_pkg::EV_RST)
  ) u_ev_sticky (
    .clk   (hclk),
    .rst_n (hresetn),
    .set   (ev_set),
    .clr   (ev_clr),
    .q     (ev_q),
    .q_nxt (ev_q_nxt)
  );

  // read data sampled from next-state values so a write in the preceding
  // data phase is already visible with no wait state
  always_comb begin
    dp_wr_nxt   = addr_phase && hwrite && (hsize == cpsr_pkg::HSIZE_WORD);
    dp_addr_nxt = addr_phase ? haddr[7:0] : dp_addr_r;
    hrdata_nxt  = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        cpsr_pkg::OFF_STATUS:     hrdata_nxt = {16'h0000, status_nxt};
        cpsr_pkg::OFF_CORE_CTRL:  hrdata_nxt = {28'h0000000, core_msb_nxt, 3'h0};
        cpsr_pkg::OFF_INTR_CTRL1: hrdata_nxt = {16'h0000, nest_dis_nxt, 15'h0000};
        cpsr_pkg::OFF_EV_STATUS:  hrdata_nxt = {29'h00000000, ev_q_nxt};
        cpsr_pkg::OFF_EV_ENABLE:  hrdata_nxt = {29'h00000000, ev_en_nxt};
        cpsr_pkg::OFF_PRIORITY:   hrdata_nxt = {27'h0000000,
                                               core_msb_nxt || (status_nxt[7:5] == cpsr_pkg::IPL_USER_OFF),
                                               core_msb_nxt, status_nxt[cpsr_pkg::B_IPL_LO +: 3]};
        default:                  hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r     <= 1'b0;
      dp_addr_r   <= 8'h00;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
      hresp_r     <= 1'b0;
    end else begin
      dp_wr_r     <= dp_wr_nxt;
      dp_addr_r   <= dp_addr_nxt;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata           = hrdata_r;
  assign hreadyout        = hreadyout_r;
  assign hresp            = hresp_r;
  assign cpu_status_reg   = status_r;
  assign cpu_priority     = prio_r;
  assign user_irq_blocked = blocked_r;
  assign irq              = irq_r;

  // checking
  logic [16:0] chk_word;
  logic [8:0]  chk_lo;
  logic        chk_add;
  logic        chk_ov;

  assign chk_word = {1'b0, alu_upd.op_a} + {1'b0, alu_upd.op_b};
  assign chk_lo   = {1'b0, alu_upd.op_a[7:0]} + {1'b0, alu_upd.op_b[7:0]};
  assign chk_add  = alu_upd.valid && !alu_upd.is_byte && !alu_upd.is_sub;
  assign chk_ov   = (alu_upd.op_a[15] == alu_upd.op_b[15]) && (chk_word[15] != alu_upd.op_a[15]);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  prio_join_a: assert property ( // see RL2
    wr_core |=> cpu_priority[3] == $past(hwdata[3]) && cpu_priority[2:0] == status_r[7:5])
    else $error("effective priority not joined from control msb and level");

  user_block_a: assert property ( // see RL3
    user_irq_blocked == (cpu_priority[3] || cpu_priority[2:0] == 3'h7))
    else $error("user interrupt block disagrees with priority");

  ipl_lock_a: assert property ( // see RL4
    wr_status && nest_dis_r && !ipl_upd.load |=> status_r[7:5] == $past(status_r[7:5]))
    else $error("priority field changed by write while nesting disabled");

  ipl_write_a: assert property ( // see RL1
    wr_status && !nest_dis_r && !ipl_upd.load |=> status_r[7:5] == $past(hwdata[7:5]))
    else $error("priority field write not taken");

  sat_clear_a: assert property ( // see RL5
    wr_status && !hwdata[10] && !(acc_upd.valid && (acc_upd.sat_a || acc_upd.sat_b))
    |=> status_r[13:12] == 2'h0 && !status_r[10])
    else $error("combined saturation clear did not clear both flags");

  sat_hold_a: assert property ( // see RL13
    status_r[13] && !wr_status |=> status_r[13] [*1])
    else $error("saturation flag dropped without a write");

  combined_ovf_a: assert property ( // see RL13
    status_r[11] == (status_r[15] || status_r[14]))
    else $error("combined overflow is not the OR of both");

  repeat_track_a: assert property ( // see RL7
    ##1 status_r[4] == $past(repeat_busy))
    else $error("repeat flag does not follow loop state");

  loop_track_a: assert property ( // see RL14
    do_loop_busy ##1 !do_loop_busy |=> !status_r[9])
    else $error("loop flag stuck after loop end");

  neg_flag_a: assert property ( // see RL8
    chk_add |=> status_r[3] == $past(chk_word[15]))
    else $error("negative flag wrong after word add");

  ovf_flag_a: assert property ( // see RL9
    chk_add |=> status_r[2] == $past(chk_ov))
    else $error("signed overflow flag wrong after word add");

  zero_flag_a: assert property ( // see RL10
    chk_add |=> status_r[1] == ($past(chk_word[15:0]) == 16'h0000))
    else $error("zero flag wrong after word add");

  carry_flag_a: assert property ( // see RL11
    chk_add |=> status_r[0] == $past(chk_word[16]))
    else $error("carry flag wrong after word add");

  nibble_flag_a: assert property ( // see RL12
    chk_add |=> status_r[8] == $past(chk_lo[8]))
    else $error("nibble carry wrong after word add");

  irq_level_a: assert property (
    |(ev_q & ev_en_r) |-> irq)
    else $error("enabled pending event without interrupt");

  alu_word_c: cover property (chk_add ##1 status_r[2]);
  sat_clear_c: cover property (status_r[13] && status_r[12] ##1 wr_status && !hwdata[10]);
  ipl_lock_c: cover property (nest_dis_r && wr_status);
  irq_rise_c: cover property (!irq ##1 irq);

endmodule // cpsr_flag_reg

// File: cpsr_core_model.sv
/*
  Behavioural model of the processor core around the status register: ALU,
  accumulator engine, loop hardware and priority loads from the interrupt logic.
  Assumes the bench calls its tasks just after a rising hclk edge.
*/
module cpsr_core_model (
  input  wire logic          hclk,
  output cpsr_pkg::cpsr_alu_t alu_upd,
  output cpsr_pkg::cpsr_acc_t acc_upd,
  output cpsr_pkg::cpsr_ipl_t ipl_upd,
  output logic               do_loop_busy,
  output logic               repeat_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    alu_upd = '0;
    acc_upd = '0;
    ipl_upd = '0;
    do_loop_busy = 1'b0;
    repeat_busy = 1'b0;
  end

  task automatic tick;
    @(posedge hclk);
    #1;
  endtask

  // idle fields are inverted so stale operands never resemble a live update
  task automatic alu_op(input logic byt, input logic sub, input logic [15:0] a, input logic [15:0] b);
    alu_upd <= '{1'b1, byt, sub, a, b};
    tick;
    alu_upd <= '{1'b0, ~byt, ~sub, ~a, ~b};
    // one idle edge after each pulse, so back-to-back calls never drive twice in one step
    tick;
  endtask

  task automatic acc_op(input logic [3:0] f);
    acc_upd <= {1'b1, f};
    tick;
    acc_upd <= {1'b0, ~f};
    tick;
  endtask

  task automatic ipl_load(input logic [2:0] l);
    ipl_upd <= {1'b1, l};
    tick;
    ipl_upd <= {1'b0, ~l};
    tick;
  endtask

  task automatic set_loops(input logic d, input logic r);
    do_loop_busy <= d;
    repeat_busy <= r;
  endtask
endmodule // cpsr_core_model

// File: cpsr_flag_reg_bench.sv
/*
  Self-checking bench for the status flag register: AHB-Lite register tasks
  and a core model drive it. Assumes zero-wait slave, hready tied to hreadyout.
*/
module cpsr_flag_reg_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy_s = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_s, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hreadyout, hresp, ublk, irq;
  logic [15:0] st;
  logic [3:0]  pri;
  cpsr_pkg::cpsr_alu_t alu_upd;
  cpsr_pkg::cpsr_acc_t acc_upd;
  cpsr_pkg::cpsr_ipl_t ipl_upd;
  logic        dlb, rpb;
  int          n_fail = 0, tests_run = 0;
  logic [1:0]  k_m [6] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b10, 2'b10};
  logic [15:0] k_a [6] = '{16'h7fff, 16'hffff, 16'h0005, 16'h0000, 16'h000f, 16'h0080};
  logic [15:0] k_b [6] = '{16'h0001, 16'h0001, 16'h0005, 16'h0001, 16'h0001, 16'h0080};

  always #50 hclk = ~hclk;
  // values seen by the master at the edge itself, free of update races
  always @(posedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end

  cpsr_flag_reg dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .alu_upd(alu_upd), .acc_upd(acc_upd), .ipl_upd(ipl_upd),
    .do_loop_busy(dlb), .repeat_busy(rpb), .cpu_status_reg(st), .cpu_priority(pri),
    .user_irq_blocked(ublk), .irq(irq));

  cpsr_core_model core (.hclk(hclk), .alu_upd(alu_upd), .acc_upd(acc_upd), .ipl_upd(ipl_upd),
    .do_loop_busy(dlb), .repeat_busy(rpb));

  task automatic tick;
    @(posedge hclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      tick;
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    if (rdy_s !== 1'b1) chk("hready", 32'h1, 32'h0);
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy;
    rd = rd_s;
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, cpsr_pkg::HSIZE_WORD);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0, cpsr_pkg::HSIZE_WORD);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // flags {n, ov, z, c, dc} of a two's complement add or subtract
  function automatic logic [4:0] alu_exp(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b);
    logic [15:0] bb;
    logic [16:0] s;
    logic [8:0]  s8, lo;
    logic [4:0]  nb;
    bb = m[0] ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {16'h0, m[0]};
    lo = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h0, m[0]};
    nb = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, m[0]};
    s8 = lo;
    if (m[1])
      return {s8[7], a[7] == bb[7] && s8[7] != a[7], s8[7:0] == 8'h0, s8[8], nb[4]};
    return {s[15], a[15] == bb[15] && s[15] != a[15], s[15:0] == 16'h0, s[16], lo[8]};
  endfunction

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    chk("watchdog", 32'h1, 32'h0);
    end_sim;
  end

  initial begin
    repeat (5) @(posedge hclk);
    #1;
    chk("hreadyout_rst", 32'h0, {31'h0, hreadyout});
    chk("status_rst", 32'h0, {16'h0, st});
    hresetn <= 1'b1;
    tick;
    tick;
    rd_chk(cpsr_pkg::OFF_STATUS, 32'h0, "status");
    done("reset");

    for (int i = 0; i < 6; i++) begin
      core.alu_op(k_m[i][1], k_m[i][0], k_a[i], k_b[i]);
      chk("alu_flags", {27'h0, alu_exp(k_m[i], k_a[i], k_b[i])},
          {27'h0, st[3], st[2], st[1], st[0], st[8]});
    end
    done("alu");

    core.acc_op(4'b1010);
    chk("acc_flags", 32'h2b, {26'h0, st[15:10]});
    core.acc_op(4'b0000);
    chk("acc_flags", 32'h09, {26'h0, st[15:10]});
    core.acc_op(4'b0101);
    chk("acc_flags", 32'h1f, {26'h0, st[15:10]});
    wr32(cpsr_pkg::OFF_STATUS, 32'h0000);
    chk("clip_clear", 32'h0, {30'h0, st[13:12]});
    wr32(cpsr_pkg::OFF_STATUS, 32'h2400);
    rd_chk(cpsr_pkg::OFF_STATUS, 32'h2400, "status");
    done("accum");

    core.set_loops(1'b1, 1'b1);
    tick;
    chk("loops", 32'h3, {30'h0, st[9], st[4]});
    wr32(cpsr_pkg::OFF_STATUS, 32'h0000);
    chk("loops_ro", 32'h3, {30'h0, st[9], st[4]});
    core.set_loops(1'b0, 1'b0);
    tick;
    chk("loops", 32'h0, {30'h0, st[9], st[4]});
    done("loops");

    for (int m = 0; m < 2; m++) begin
      wr32(cpsr_pkg::OFF_CORE_CTRL, {28'h0, m[0], 3'h0});
      for (int l = 0; l < 8; l++) begin
        wr32(cpsr_pkg::OFF_STATUS, {24'h0, l[2:0], 5'h0});
        chk("priority", {28'h0, m[0], l[2:0]}, {28'h0, pri});
        chk("blocked", {31'h0, m[0] | (l == 7)}, {31'h0, ublk});
        rd_chk(cpsr_pkg::OFF_PRIORITY, {27'h0, m[0] | (l == 7), m[0], l[2:0]}, "prio_reg");
      end
    end
    wr32(cpsr_pkg::OFF_CORE_CTRL, 32'h0);
    wr32(cpsr_pkg::OFF_INTR_CTRL1, 32'h8000);
    wr32(cpsr_pkg::OFF_STATUS, 32'h0040);
    chk("prio_locked", 32'h7, {28'h0, pri});
    core.ipl_load(3'h1);
    chk("prio_load", 32'h1, {28'h0, pri});
    wr32(cpsr_pkg::OFF_INTR_CTRL1, 32'h0);
    wr32(cpsr_pkg::OFF_STATUS, 32'h0040);
    chk("prio_open", 32'h2, {28'h0, pri});
    done("priority");

    xfer(1'b1, cpsr_pkg::OFF_STATUS, 32'h0003, 3'h0);
    rd_chk(cpsr_pkg::OFF_STATUS, 32'h0040, "status_byte_wr");
    wr32(8'h1c, 32'hffff_ffff);
    rd_chk(8'h1c, 32'h0, "unmapped");
    done("bus");

    rd_chk(cpsr_pkg::OFF_EV_STATUS, 32'h7, "ev_status");
    wr32(cpsr_pkg::OFF_EV_ENABLE, 32'h4);
    tick;
    chk("irq_on", 32'h1, {31'h0, irq});
    wr32(cpsr_pkg::OFF_EV_ENABLE, 32'h0);
    tick;
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr32(cpsr_pkg::OFF_EV_CLEAR, 32'h7);
    rd_chk(cpsr_pkg::OFF_EV_STATUS, 32'h0, "ev_cleared");
    wr32(cpsr_pkg::OFF_EV_ENABLE, 32'h4);
    core.alu_op(1'b0, 1'b0, 16'h7fff, 16'h0001);
    tick;
    chk("irq_event", 32'h1, {31'h0, irq});
    wr32(cpsr_pkg::OFF_EV_CLEAR, 32'h4);
    tick;
    chk("irq_clear", 32'h0, {31'h0, irq});
    done("irq");
    end_sim;
  end
endmodule // cpsr_flag_reg_bench
